// file: hdl/spc_pkg.sv
// Shared constants, register map and carrier types of the serial port framing block.
package spc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned SCK_HALF_NS   = 80;
  localparam int unsigned SCK_HALF_CYC  = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam int unsigned BUS_ADDR_W = 16;
  localparam logic [13:0] IDX_DATA   = 14'h0F60;
  localparam logic [13:0] IDX_CMD    = 14'h0F61;
  localparam logic [13:0] IDX_CTRL   = 14'h0F62;
  localparam logic [13:0] IDX_MODE   = 14'h0F63;
  localparam logic [13:0] IDX_STAT   = 14'h0F64;
  localparam logic [13:0] IDX_STATE  = 14'h0F65;

  // ----------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------
  localparam int unsigned MODE_FRAME_LSB = 5;
  localparam int unsigned MODE_LEN_LSB   = 2;
  localparam int unsigned MODE_DIR_BIT   = 1;
  localparam int unsigned MODE_POL_BIT   = 0;
  localparam int unsigned CTRL_PE_HI_BIT = 6;
  localparam int unsigned CTRL_IDLE_BIT  = 3;
  localparam int unsigned CTRL_OD_BIT    = 2;
  localparam int unsigned CTRL_MST_BIT   = 1;
  localparam int unsigned CTRL_PE_LO_BIT = 0;
  localparam int unsigned CMD_SSV_BIT    = 0;
  localparam int unsigned STAT_TXE_BIT   = 7;
  localparam int unsigned STAT_ABT_BIT   = 4;
  localparam int unsigned STAT_RXR_BIT   = 2;
  localparam int unsigned STAT_BUSY_BIT  = 1;
  localparam int unsigned STAT_SS_BIT    = 0;
  localparam int unsigned STATE_SCK_BIT  = 7;
  localparam int unsigned STATE_SDI_BIT  = 6;
  localparam logic [7:0]  MODE_RESET     = 8'h00;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [7:0]  ONES_BYTE      = 8'hFF;
  localparam logic [3:0]  CHAR_FULL      = 4'h8;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] FRAME_SPI  = 3'h0;
  localparam logic [2:0] FRAME_LOOP = 3'h1;
  localparam logic [2:0] FRAME_SYNC = 3'h2;
  localparam logic [1:0] PE_OFF     = 2'h0;
  localparam logic [1:0] PE_TX      = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_LEAD  = 3'h2,
    ST_SHIFT = 3'h4
  } spc_state_t;

  typedef struct packed {
    logic out;
    logic oe;
  } spc_pin_t;

  typedef struct packed {
    logic sck;
    logic ss;
    logic mosi;
    logic miso;
  } spc_lines_t;

endpackage

// file: hdl/spc_sync.sv
// Two-stage synchroniser for pin inputs.
module spc_sync #(
  parameter int unsigned W = 4
) (
  input  wire logic         CLK_IN,
  input  wire logic         RST_IN,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // The first stage feeds only the second, to keep metastability contained.
  always_comb begin
    meta_d = d_in;
    sync_d = meta_q;
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q_out = sync_q;

endmodule

// file: hdl/spc_clkdiv.sv
// Divider that produces the half-period enable pulse of the serial clock.
module spc_clkdiv #(
  parameter int unsigned HALF = spc_pkg::SCK_HALF_CYC,
  parameter int unsigned W    = $clog2(HALF + 1)
) (
  input  wire logic CLK_IN,
  input  wire logic RST_IN,
  input  wire logic en_in,
  output logic      tick_out
);

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  assign tick_out = en_in && (cnt_q == W'(HALF - 1));

  always_comb begin
    cnt_d = cnt_q;
    if (!en_in || tick_out) begin
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + W'(1);
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

// file: hdl/spc_top.sv
// Serial port pin, framing and character engine with its Avalon-MM register slave.
// Overview of operation
// RL1: Clock idle level bit picks whether the serial clock rests low or high.
// RL2: Open-drain bit makes all four port pins open-drain instead of push-pull.
// RL3: As slave, data goes out on MISO, in on MOSI, clock is input.
// RL4: As master, data goes out on MOSI, in on MISO, clock is driven.
// RL5: Standard framing with select output drives SS from the select value bit.
// RL6: Master software sets select value no later than the first data write.
// RL7: Standard framing clears the select value bit after the frame's last character.
// RL8: Standard framing toggles the clock only during bits, one cycle per bit.
// RL9: Master loopback deasserts outputs and feeds transmit shifter into receive shifter.
// RL10: Slave loopback echoes MOSI straight to MISO while select is asserted.
// RL11: Synchronous master shows select one clock period before the frame data.
// RL12: Synchronous frame boundary is a select value change or SS level change.
// RL13: Synchronous framing runs frames back to back while transmit data keeps coming.
// RL14: Synchronous slave starts a transaction the clock cycle after any SS change.
// RL15: Character length code zero means eight bits, otherwise the code's bit count.
// RL16: Select direction bit makes SS an input at zero, driven output at one.
// RL17: Software sets select output for single master, input for slave or multi-master.
// RL18: Select polarity bit chooses active-low or active-high SS for the select value.
// RL19: Port enable field: off, receive only, transmit only, or both.
// RL20: Slave sets abort flag when SS drops before a full character moved.
// RL21: Reserved framing codes behave like standard framing.
//
// Design decision made here: the Avalon-MM interface to the registers.
module spc_top (
  input  wire logic        CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic [15:0] AVS_ADDRESS_IN,
  input  wire logic        AVS_READ_IN,
  input  wire logic        AVS_WRITE_IN,
  input  wire logic [31:0] AVS_WRITEDATA_IN,
  input  wire logic [3:0]  AVS_BYTEENABLE_IN,
  output logic      [31:0] AVS_READDATA_OUT,
  output logic             AVS_WAITREQUEST_OUT,
  input  wire logic        SCK_IN,
  output logic             SCK_OUT,
  output logic             SCK_OE_OUT,
  input  wire logic        SS_IN,
  output logic             SS_OUT,
  output logic             SS_OE_OUT,
  input  wire logic        MOSI_IN,
  output logic             MOSI_OUT,
  output logic             MOSI_OE_OUT,
  input  wire logic        MISO_IN,
  output logic             MISO_OUT,
  output logic             MISO_OE_OUT
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] char_bits(input logic [2:0] code);
    return (code == 3'h0) ? spc_pkg::CHAR_FULL : {1'b0, code}; // RL15
  endfunction

  function automatic spc_pkg::spc_pin_t pin_drive(input logic v, input logic drv,
                                                  input logic od);
    spc_pkg::spc_pin_t p;
    p.out = od ? 1'b0 : v; // RL2
    p.oe  = drv & (od ? ~v : 1'b1); // RL2
    return p;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  spc_pkg::spc_state_t st_q, st_d;
  spc_pkg::spc_lines_t pins_raw, pins_s;
  logic [7:0]  mode_q, mode_d, ctrl_q, ctrl_d, txbuf_q, txbuf_d, rxbuf_q, rxbuf_d;
  logic [7:0]  txsh_q, txsh_d, rxsh_q, rxsh_d;
  logic [3:0]  cnt_q, cnt_d;
  logic        ssv_q, ssv_d, txfull_q, txfull_d, rxrdy_q, rxrdy_d, abort_q, abort_d;
  logic        half_q, half_d, sck_q, sck_d, lastssv_q, lastssv_d, run_q, run_d;
  logic        ssprev_q, sckprev_q, ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic        do_load, char_done, abort_evt, frame_end, tick;
  logic        bus_acc, wr_fire, rd_fire;
  logic [13:0] idx;
  logic [2:0]  frame;
  logic [1:0]  pe;
  logic [3:0]  nbits;
  logic        en, master, idle, od, dir, pol, sync, loop, loop_m, ss_act, din;
  logic        lead_e, trail_e, ss_chg, pe_tx, pe_rx;
  spc_pkg::spc_pin_t sck_p, ss_p, mosi_p, miso_p;

  // ----------------------------------------------------------------
  // Pin synchronisers and clock divider
  // ----------------------------------------------------------------
  assign pins_raw = '{sck: SCK_IN, ss: SS_IN, mosi: MOSI_IN, miso: MISO_IN};

  spc_sync #(.W(4)) u_sync (
    .CLK_IN (CLK_IN),
    .RST_IN (RST_IN),
    .d_in   (pins_raw),
    .q_out  (pins_s)
  );

  spc_clkdiv #(.HALF(spc_pkg::SCK_HALF_CYC)) u_div (
    .CLK_IN   (CLK_IN),
    .RST_IN   (RST_IN),
    .en_in    (en && master),
    .tick_out (tick)
  );

  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------
  assign frame  = mode_q[spc_pkg::MODE_FRAME_LSB +: 3];
  assign nbits  = char_bits(mode_q[spc_pkg::MODE_LEN_LSB +: 3]);
  assign dir    = mode_q[spc_pkg::MODE_DIR_BIT];
  assign pol    = mode_q[spc_pkg::MODE_POL_BIT];
  assign pe     = {ctrl_q[spc_pkg::CTRL_PE_HI_BIT], ctrl_q[spc_pkg::CTRL_PE_LO_BIT]};
  assign idle   = ctrl_q[spc_pkg::CTRL_IDLE_BIT];
  assign od     = ctrl_q[spc_pkg::CTRL_OD_BIT];
  assign master = ctrl_q[spc_pkg::CTRL_MST_BIT];
  assign en     = (pe != spc_pkg::PE_OFF); // RL19
  assign pe_tx  = pe[1]; // RL19
  assign pe_rx  = pe[0]; // RL19
  // Any code other than loopback or synchronous falls back to standard framing.
  assign sync   = (frame == spc_pkg::FRAME_SYNC); // RL21
  assign loop   = (frame == spc_pkg::FRAME_LOOP); // RL21
  assign loop_m = loop && master;
  assign ss_act = ~(pins_s.ss ^ pol); // RL18
  assign lead_e = (pins_s.sck != sckprev_q) && (pins_s.sck != idle);
  assign trail_e = (pins_s.sck != sckprev_q) && (pins_s.sck == idle);
  assign ss_chg = (pins_s.ss != ssprev_q); // RL12
  assign din    = master ? (loop ? txsh_q[7] : pins_s.miso) : pins_s.mosi; // RL3 RL4 RL9

  // ----------------------------------------------------------------
  // Bus slave: one wait state, then the answer
  // ----------------------------------------------------------------
  assign idx     = AVS_ADDRESS_IN[spc_pkg::BUS_ADDR_W-1:2];
  assign bus_acc = (AVS_READ_IN || AVS_WRITE_IN) && !ack_q;
  assign wr_fire = AVS_WRITE_IN && ack_q && AVS_BYTEENABLE_IN[0];
  assign rd_fire = AVS_READ_IN && ack_q;
  assign AVS_WAITREQUEST_OUT = bus_acc;
  assign AVS_READDATA_OUT    = rdata_q;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;     cnt_d = cnt_q;     half_d = half_q;     sck_d = sck_q;
    txsh_d = txsh_q; rxsh_d = rxsh_q;   txbuf_d = txbuf_q;   txfull_d = txfull_q;
    rxbuf_d = rxbuf_q; rxrdy_d = rxrdy_q; abort_d = abort_q; ssv_d = ssv_q;
    lastssv_d = lastssv_q; run_d = run_q; mode_d = mode_q;  ctrl_d = ctrl_q;
    ack_d = bus_acc; rdata_d = rdata_q;
    do_load = 1'b0;  char_done = 1'b0;  abort_evt = 1'b0;   frame_end = 1'b0;
    if (!en) begin
      st_d = spc_pkg::ST_IDLE;
      cnt_d = 4'h0;
      half_d = 1'b0;
      run_d = 1'b0;
    end else if (master) begin
      case (st_q)
        spc_pkg::ST_IDLE: begin
          sck_d = idle; // RL1
          if (txfull_q && pe_tx) begin
            do_load = 1'b1;
            cnt_d = 4'h0;
            half_d = 1'b0;
            lastssv_d = ssv_q;
            // In synchronous framing a changed select value is a new frame and earns one lead period.
            st_d = (sync && (ssv_q != lastssv_q)) ? spc_pkg::ST_LEAD : spc_pkg::ST_SHIFT; // RL11 RL12
          end
        end
        spc_pkg::ST_LEAD: begin
          if (tick) begin
            sck_d = ~sck_q; // RL11
            half_d = ~half_q;
            if (half_q) begin
              st_d = spc_pkg::ST_SHIFT; // RL11
            end
          end
        end
        spc_pkg::ST_SHIFT: begin
          if (tick && !half_q) begin
            sck_d = ~idle; // RL8
            rxsh_d = {rxsh_q[6:0], din}; // RL9
            half_d = 1'b1;
          end else if (tick) begin
            sck_d = idle; // RL8
            half_d = 1'b0;
            txsh_d = {txsh_q[6:0], 1'b1};
            cnt_d = cnt_q + 4'h1;
            if (cnt_q + 4'h1 == nbits) begin
              char_done = 1'b1; // RL15
              // Returning to idle costs no clock edge: the divider keeps its pace.
              st_d = spc_pkg::ST_IDLE; // RL13
              frame_end = !txfull_q && !sync && !loop; // RL7
            end
          end
        end
        default: st_d = spc_pkg::ST_IDLE;
      endcase
    end else begin
      case (st_q)
        spc_pkg::ST_IDLE: begin
          if (sync ? run_q : ss_act) begin
            do_load = 1'b1;
            cnt_d = 4'h0;
            half_d = 1'b0;
            st_d = spc_pkg::ST_SHIFT;
          end
        end
        spc_pkg::ST_LEAD: begin
          if (trail_e) begin
            do_load = 1'b1; // RL14
            cnt_d = 4'h0;
            half_d = 1'b0;
            st_d = spc_pkg::ST_SHIFT; // RL14
          end
        end
        spc_pkg::ST_SHIFT: begin
          if (lead_e) begin
            rxsh_d = {rxsh_q[6:0], din}; // RL3
            half_d = 1'b1;
          end else if (trail_e && half_q) begin
            txsh_d = {txsh_q[6:0], 1'b1};
            half_d = 1'b0;
            cnt_d = cnt_q + 4'h1;
            if (cnt_q + 4'h1 == nbits) begin
              char_done = 1'b1; // RL15
              st_d = spc_pkg::ST_IDLE;
            end
          end
        end
        default: st_d = spc_pkg::ST_IDLE;
      endcase
      if (sync && ss_chg) begin
        abort_evt = (st_q == spc_pkg::ST_SHIFT) && ((cnt_q != 4'h0) || half_q); // RL20
        run_d = 1'b1;
        do_load = 1'b0;
        st_d = spc_pkg::ST_LEAD; // RL12 RL14
      end else if (!sync && !ss_act && (st_q == spc_pkg::ST_SHIFT)) begin
        abort_evt = (cnt_q != 4'h0) || half_q; // RL20
        do_load = 1'b0;
        st_d = spc_pkg::ST_IDLE;
      end
      if (!sync) begin
        run_d = 1'b0;
      end
    end
    if (do_load) begin
      // Short characters are left-aligned so the most significant bit leaves first.
      txsh_d = (pe_tx && txfull_q) ? (txbuf_q << (spc_pkg::CHAR_FULL - nbits))
                                   : spc_pkg::ONES_BYTE;
      txfull_d = 1'b0;
    end
    if (frame_end) begin
      ssv_d = 1'b0; // RL7
    end
    if (rd_fire && (idx == spc_pkg::IDX_DATA)) begin
      rxrdy_d = 1'b0;
    end
    if (char_done && pe_rx) begin
      rxbuf_d = rxsh_q & (spc_pkg::ONES_BYTE >> (spc_pkg::CHAR_FULL - nbits)); // RL15
      rxrdy_d = 1'b1;
    end
    if (wr_fire) begin
      case (idx)
        spc_pkg::IDX_DATA: begin
          txbuf_d = AVS_WRITEDATA_IN[7:0];
          txfull_d = 1'b1;
        end
        spc_pkg::IDX_CMD:  ssv_d = AVS_WRITEDATA_IN[spc_pkg::CMD_SSV_BIT];
        spc_pkg::IDX_CTRL: ctrl_d = AVS_WRITEDATA_IN[7:0];
        spc_pkg::IDX_MODE: mode_d = AVS_WRITEDATA_IN[7:0];
        spc_pkg::IDX_STAT: abort_d = abort_q && !AVS_WRITEDATA_IN[spc_pkg::STAT_ABT_BIT];
        default: ;
      endcase
    end
    if (abort_evt) begin
      abort_d = 1'b1; // RL20
    end
    if (bus_acc && AVS_READ_IN) begin
      rdata_d = 32'h0000_0000;
      case (idx)
        spc_pkg::IDX_DATA:  rdata_d[7:0] = rxbuf_q;
        spc_pkg::IDX_CMD:   rdata_d[spc_pkg::CMD_SSV_BIT] = ssv_q;
        spc_pkg::IDX_CTRL:  rdata_d[7:0] = ctrl_q;
        spc_pkg::IDX_MODE:  rdata_d[7:0] = mode_q;
        spc_pkg::IDX_STAT: begin
          rdata_d[spc_pkg::STAT_TXE_BIT]  = !txfull_q;
          rdata_d[spc_pkg::STAT_ABT_BIT]  = abort_q;
          rdata_d[spc_pkg::STAT_RXR_BIT]  = rxrdy_q;
          rdata_d[spc_pkg::STAT_BUSY_BIT] = (st_q != spc_pkg::ST_IDLE);
          rdata_d[spc_pkg::STAT_SS_BIT]   = pins_s.ss;
        end
        spc_pkg::IDX_STATE: begin
          rdata_d[spc_pkg::STATE_SCK_BIT] = pins_s.sck;
          rdata_d[spc_pkg::STATE_SDI_BIT] = master ? pins_s.miso : pins_s.mosi;
          rdata_d[2:0] = st_q;
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      st_q <= spc_pkg::ST_IDLE;  cnt_q <= 4'h0;  half_q <= 1'b0;  sck_q <= 1'b0;
      txsh_q <= spc_pkg::ONES_BYTE; rxsh_q <= 8'h00; txbuf_q <= 8'h00; txfull_q <= 1'b0;
      rxbuf_q <= 8'h00; rxrdy_q <= 1'b0; abort_q <= 1'b0; ssv_q <= 1'b0;
      lastssv_q <= 1'b0; run_q <= 1'b0; mode_q <= spc_pkg::MODE_RESET;
      ctrl_q <= spc_pkg::CTRL_RESET; ack_q <= 1'b0; rdata_q <= 32'h0000_0000;
      ssprev_q <= 1'b0; sckprev_q <= 1'b0;
    end else begin
      st_q <= st_d;  cnt_q <= cnt_d;  half_q <= half_d;  sck_q <= sck_d;
      txsh_q <= txsh_d; rxsh_q <= rxsh_d; txbuf_q <= txbuf_d; txfull_q <= txfull_d;
      rxbuf_q <= rxbuf_d; rxrdy_q <= rxrdy_d; abort_q <= abort_d; ssv_q <= ssv_d;
      lastssv_q <= lastssv_d; run_q <= run_d; mode_q <= mode_d;
      ctrl_q <= ctrl_d; ack_q <= ack_d; rdata_q <= rdata_d;
      ssprev_q <= pins_s.ss; sckprev_q <= pins_s.sck;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // The slave echo is a pure wire path, so it passes the pin with no clock delay.
  always_comb begin
    sck_p  = pin_drive(loop_m ? idle : sck_q, en && master, od); // RL1 RL4 RL9
    mosi_p = pin_drive(loop_m ? 1'b1 : txsh_q[7], en && master, od); // RL4 RL9
    ss_p   = pin_drive(loop_m ? ~pol : ~(ssv_q ^ pol), en && dir, od); // RL5 RL16 RL18
    miso_p = pin_drive((loop && ss_act) ? MOSI_IN : txsh_q[7],
                       en && !master && (ss_act || sync), od); // RL3 RL10
  end

  assign SCK_OUT     = sck_p.out;
  assign SCK_OE_OUT  = sck_p.oe;
  assign SS_OUT      = ss_p.out;
  assign SS_OE_OUT   = ss_p.oe;
  assign MOSI_OUT    = mosi_p.out;
  assign MOSI_OE_OUT = mosi_p.oe;
  assign MISO_OUT    = miso_p.out;
  assign MISO_OE_OUT = miso_p.oe;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);

  a_sck_idle_rest: assert property (en && master && !od && st_q == spc_pkg::ST_IDLE
    |=> SCK_OUT == $past(idle)) else $error("serial clock not at idle level"); // RL1
  a_od_no_high: assert property (od |-> !(SCK_OE_OUT && SCK_OUT) && !(SS_OE_OUT && SS_OUT)
    && !(MOSI_OE_OUT && MOSI_OUT) && !(MISO_OE_OUT && MISO_OUT))
    else $error("open-drain pin driven high"); // RL2
  a_slave_dir: assert property (!master |-> !SCK_OE_OUT && !MOSI_OE_OUT)
    else $error("slave drives clock or MOSI"); // RL3
  a_master_dir: assert property (en && master && !od |-> SCK_OE_OUT && MOSI_OE_OUT
    && !MISO_OE_OUT) else $error("master pin directions wrong"); // RL4
  a_ss_follow: assert property (en && dir && !loop_m && !od
    |-> SS_OE_OUT && SS_OUT == (pol ? ssv_q : ~ssv_q)) else $error("SS level wrong"); // RL5
  a_ssv_autoclr: assert property (frame_end && !(wr_fire && idx == spc_pkg::IDX_CMD)
    |=> !ssv_q) else $error("select value not cleared at frame end"); // RL7
  // A new idle level or a fresh enable moves the clock once in idle; only true toggles count.
  a_sck_only_bits: assert property (en && master && !sync && $changed(sck_q) && $past(en, 2)
    && $past(idle, 2) == $past(idle)
    |-> $past(st_q) == spc_pkg::ST_SHIFT) else $error("clock moved outside bits"); // RL8
  a_loop_quiet: assert property (en && loop_m && !od |-> SCK_OUT == idle && MOSI_OUT)
    else $error("loopback master outputs not deasserted"); // RL9
  a_loop_echo: assert property (en && loop && !master && ss_act && !od
    |-> MISO_OUT == MOSI_IN) else $error("slave echo broken"); // RL10
  a_sync_lead: assert property (master && st_q == spc_pkg::ST_LEAD && tick && half_q
    |=> st_q == spc_pkg::ST_SHIFT) else $error("lead period wrong length"); // RL11
  a_sync_restart: assert property (en && !master && sync && ss_chg
    |=> st_q == spc_pkg::ST_LEAD) else $error("SS change did not restart"); // RL14
  a_char_count: assert property (char_done |-> cnt_d == nbits && cnt_d != 4'h0)
    else $error("character length mismatch"); // RL15
  a_tx_only: assert property (en && !pe_rx && !rxrdy_q |=> !rxrdy_q)
    else $error("receive ready in transmit only mode"); // RL19
  a_abort_set: assert property (abort_evt |=> abort_q) else $error("abort flag lost"); // RL20

  c_master_char: cover property (master && !sync && char_done ##[1:50] frame_end);
  c_sync_lead: cover property (master && sync && st_q == spc_pkg::ST_LEAD);
  c_slave_abort: cover property (!master && abort_evt);
  c_slave_echo: cover property (!master && loop && ss_act && MISO_OE_OUT);

endmodule

// file: sim/spc_peer.sv
// Behavioural serial peer that answers a master with a fixed character.
module spc_peer (
  input  wire logic       sck_in,
  input  wire logic       ss_n_in,
  input  wire logic       mosi_in,
  output logic            miso_out,
  output logic [7:0]      got_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh = 8'h00;
  initial got_out = 8'h00;
  always @(negedge ss_n_in) sh = 8'h3C;
  always @(posedge sck_in) if (!ss_n_in) got_out = {got_out[6:0], mosi_in};
  always @(negedge sck_in) if (!ss_n_in) sh = {sh[6:0], ~sh[0]};
  // A released line shows the inverse so a stale value is never mistaken for data.
  assign miso_out = ss_n_in ? ~sh[7] : sh[7];
endmodule

// file: sim/tb_spc_top.sv
// Self-checking bench of the serial port framing block.
module tb_spc_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK_IN = 0, RST_IN = 1, AVS_READ_IN = 0, AVS_WRITE_IN = 0;
  logic [15:0] AVS_ADDRESS_IN = 16'h0000;
  logic [31:0] AVS_WRITEDATA_IN = 32'h0, AVS_READDATA_OUT, rd;
  logic [3:0]  AVS_BYTEENABLE_IN = 4'hF;
  logic        AVS_WAITREQUEST_OUT, SCK_OUT, SCK_OE_OUT, SS_OUT, SS_OE_OUT;
  logic        MOSI_OUT, MOSI_OE_OUT, MISO_OUT, MISO_OE_OUT, peer_miso;
  logic        tb_sck = 0, tb_ss = 1, tb_mosi = 0;
  logic [7:0]  peer_got;
  int          mismatches = 0, samples_checked = 0, cyc = 0, edges = 0;
  wire logic   SCK_IN = SCK_OE_OUT ? SCK_OUT : tb_sck;
  wire logic   SS_IN = SS_OE_OUT ? SS_OUT : tb_ss;
  wire logic   MOSI_IN = MOSI_OE_OUT ? MOSI_OUT : tb_mosi;
  wire logic   MISO_IN = MISO_OE_OUT ? MISO_OUT : peer_miso;
  spc_top i_dut (.*);
  spc_peer i_peer (.sck_in(SCK_IN), .ss_n_in(SS_IN), .mosi_in(MOSI_IN),
                   .miso_out(peer_miso), .got_out(peer_got));
  initial forever #2 CLK_IN = ~CLK_IN;
  always @(posedge SCK_IN) edges++;
  always @(posedge CLK_IN) if (++cyc == 30000) begin
    mismatches++;
    summarize();
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // The idle edge after release keeps a back-to-back call off the same time step.
  task automatic bus(input logic w, input logic [13:0] a, input logic [7:0] d);
    AVS_ADDRESS_IN <= {a, 2'b00};
    AVS_WRITEDATA_IN <= {24'h0, d};
    AVS_WRITE_IN <= w;
    AVS_READ_IN <= !w;
    do @(posedge CLK_IN); while (AVS_WAITREQUEST_OUT !== 1'b0);
    rd = AVS_READDATA_OUT;
    AVS_WRITE_IN <= 0;
    AVS_READ_IN <= 0;
    @(posedge CLK_IN);
  endtask
  task automatic wait_rx();
    repeat (400) begin
      bus(0, spc_pkg::IDX_STAT, 0);
      if (rd[spc_pkg::STAT_RXR_BIT] === 1'b1) break;
    end
    chk(rd[spc_pkg::STAT_RXR_BIT], 1);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    bus(0, spc_pkg::IDX_MODE, 0);
    chk(rd, 32'h0);
    bus(1, spc_pkg::IDX_MODE, 8'hFF);
    bus(0, spc_pkg::IDX_MODE, 0);
    chk(rd, 32'hFF);
    bus(0, 14'h0100, 0);
    chk(rd, 32'h0);
    bus(1, spc_pkg::IDX_CTRL, 8'h4E);
    @(posedge CLK_IN);
    chk(SCK_OE_OUT, 0);
    bus(1, spc_pkg::IDX_CTRL, 8'h4A);
    chk({SCK_OE_OUT, SCK_OUT}, 2'h3);
    chk({SS_OE_OUT, SS_OUT}, 2'h2);
  endtask
  task automatic t_master();
    bus(1, spc_pkg::IDX_MODE, 8'h02);
    bus(1, spc_pkg::IDX_CTRL, 8'h43);
    chk(SS_OUT, 1);
    bus(1, spc_pkg::IDX_CMD, 1);
    chk(SS_OUT, 0);
    edges = 0;
    bus(1, spc_pkg::IDX_DATA, 8'hA5);
    wait_rx();
    chk(edges, 8);
    chk(peer_got, 8'hA5);
    chk(SS_OUT, 1);
    bus(0, spc_pkg::IDX_DATA, 0);
    chk(rd, 32'h3C);
  endtask
  task automatic t_loop(input logic [7:0] m, input logic [7:0] d);
    bus(1, spc_pkg::IDX_MODE, m);
    bus(1, spc_pkg::IDX_CMD, 1);
    edges = 0;
    bus(1, spc_pkg::IDX_DATA, d);
    wait_rx();
    bus(0, spc_pkg::IDX_DATA, 0);
    chk(rd, {24'h0, d});
    chk({edges[0], SS_OUT}, 2'h1);
  endtask
  // A changed select value earns one lead clock period, so the peer sees nine rising edges.
  task automatic t_sync();
    bus(1, spc_pkg::IDX_MODE, 8'h43);
    bus(1, spc_pkg::IDX_CMD, 0);
    chk(SS_OUT, 0);
    edges = 0;
    bus(1, spc_pkg::IDX_DATA, 8'h96);
    wait_rx();
    chk(edges, 9);
    chk({peer_got, SS_OUT}, 9'h12C);
    bus(0, spc_pkg::IDX_DATA, 0);
    chk(rd, 32'h79);
  endtask
  task automatic t_slave();
    bus(1, spc_pkg::IDX_CTRL, 8'h41);
    bus(1, spc_pkg::IDX_MODE, 8'h20);
    chk({SCK_OE_OUT, MOSI_OE_OUT}, 2'h0);
    tb_ss <= 0;
    repeat (4) @(posedge CLK_IN);
    tb_mosi <= 1;
    @(posedge CLK_IN);
    chk(MISO_OUT, 1);
    tb_mosi <= 0;
    @(posedge CLK_IN);
    chk(MISO_OUT, 0);
    tb_sck <= 1;
    repeat (4) @(posedge CLK_IN);
    tb_ss <= 1;
    repeat (4) @(posedge CLK_IN);
    bus(0, spc_pkg::IDX_STAT, 0);
    chk(rd[spc_pkg::STAT_ABT_BIT], 1);
  endtask
  initial begin
    repeat (20) @(posedge CLK_IN);
    RST_IN <= 0;
    @(posedge CLK_IN);
    t_regs();
    t_master();
    t_loop(8'h22, 8'h5A);
    t_loop(8'h32, 8'h0A);
    t_sync();
    t_slave();
    summarize();
  end
endmodule
